// File: logic/gp_port_map.svh
// Register map, field positions and reset values of the general-purpose pin port.
`ifndef GP_PORT_MAP_SVH
`define GP_PORT_MAP_SVH

`define GP_PORT_REG_OFFSET   32'h0000_0000
`define GP_PORT_SEL_BIT      8
`define GP_PORT_MD_MSB       7
`define GP_PORT_MD_LSB       0
`define GP_PORT_DIR_RESET    8'h00
`define GP_PORT_DATA_RESET   8'h00
`define GP_PORT_SEL_RESET    1'b0
`define GP_PORT_UPPER_READ   23'h7fffff

`endif

// File: logic/gp_port_pkg.sv
// Types shared by the general-purpose pin port files.
package gp_port_pkg;
	typedef enum logic [1:0] {
		AHB_IDLE,
		AHB_WRITE,
		AHB_READ
	} ahb_phase_t;
endpackage

// File: logic/gp_pin_sync.sv
// Two-stage synchroniser for the general-purpose pin inputs.
`timescale 1ns/1ps
module gp_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// Asynchronous pins and their synchronised copies.
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1_r;

	// The first stage feeds only the second, so metastability never reaches logic.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			stage1_r <= '0;
			pin_sync <= '0;
		end else begin
			stage1_r <= pin_async;
			pin_sync <= stage1_r;
		end
	end
endmodule // gp_pin_sync

// File: logic/gp_pin_drive.sv
// Per-pin output drivers and read-back muxing for the general-purpose port.
`timescale 1ns/1ps
module gp_pin_drive #(
	parameter int WIDTH = 8
) (
	// Stored state.
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] pin_in,
	// Pin drive.
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe_n,
	// Value seen by a data-mode read.
	output logic      [WIDTH-1:0] level
);
	// Each pin is handled alike: driven when it is an output, sampled otherwise.
	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		assign pin_out[i]  = data[i];
		assign pin_oe_n[i] = ~dir[i]; // R3
		assign level[i]    = dir[i] ? data[i] : pin_in[i]; // R6
	end
endmodule // gp_pin_drive

// File: logic/gp_port.sv
// General-purpose pin port with an AHB-Lite register slave.
// Function
// R1: Eight general-purpose pins controlled by one host-visible port register.
// R2: Bit 8 selects whether low-byte accesses act on direction or data.
// R3: Direction mode: a low-byte write sets directions, 1 output, 0 input.
// R4: Hardware reset makes all eight pins inputs, none driven.
// R5: Data mode: a low-byte write sets levels on output pins.
// R6: Data-mode read gives input pin levels and output pin driven values.
// R7: Directions and data stored apart; data to inputs waits until output.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "gp_port_map.svh"
module gp_port #(
	parameter int PINS = 8
) (
	// Clock and reset.
	input  wire logic            clk_sys,
	input  wire logic            resetn,
	// AHB-Lite slave.
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	// General-purpose pins.
	input  wire logic [PINS-1:0] pin_in,
	output logic      [PINS-1:0] pin_out,
	output logic      [PINS-1:0] pin_oe_n
);
	logic [PINS-1:0]          dir_r;
	logic [PINS-1:0]          data_r;
	logic                     sel_r;
	logic [PINS-1:0]          pin_sync;
	logic [PINS-1:0]          level;
	logic                     hit;
	logic                     start;
	gp_port_pkg::ahb_phase_t  phase_r;
	logic [31:0]              rdata_nxt;

	// External pins cross into the bus clock domain before anything reads them.
	gp_pin_sync #(.WIDTH(PINS)) u_sync (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.pin_async (pin_in),
		.pin_sync  (pin_sync)
	);

	// Pin buffers and the read-back mux.
	gp_pin_drive #(.WIDTH(PINS)) u_drive (
		.dir      (dir_r),
		.data     (data_r),
		.pin_in   (pin_sync),
		.pin_out  (pin_out),
		.pin_oe_n (pin_oe_n),
		.level    (level)
	);

	// Address phase decode; only the one word register answers.
	assign hit   = (haddr[31:2] == 30'(`GP_PORT_REG_OFFSET >> 2));
	assign start = hsel && htrans[1] && hready;

	// Data-phase bookkeeping; unmapped accesses are taken and ignored.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			phase_r <= gp_port_pkg::AHB_IDLE;
		end else if (start && hit) begin
			phase_r <= hwrite ? gp_port_pkg::AHB_WRITE : gp_port_pkg::AHB_READ;
		end else begin
			phase_r <= gp_port_pkg::AHB_IDLE;
		end
	end

	// Mode select bit is written on every register write.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sel_r <= `GP_PORT_SEL_RESET;
		end else if (phase_r == gp_port_pkg::AHB_WRITE) begin
			sel_r <= hwdata[`GP_PORT_SEL_BIT]; // R2
		end
	end

	// Direction storage; reset leaves every pin undriven.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dir_r <= `GP_PORT_DIR_RESET; // R4
		end else if (phase_r == gp_port_pkg::AHB_WRITE && hwdata[`GP_PORT_SEL_BIT]) begin
			dir_r <= hwdata[`GP_PORT_MD_MSB:`GP_PORT_MD_LSB]; // R3
		end
	end

	// Output data storage, kept apart so an input pin's value waits until it turns output.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			data_r <= `GP_PORT_DATA_RESET;
		end else if (phase_r == gp_port_pkg::AHB_WRITE && !hwdata[`GP_PORT_SEL_BIT]) begin
			data_r <= hwdata[`GP_PORT_MD_MSB:`GP_PORT_MD_LSB]; // R5 R7
		end
	end

	// Read value: in direction mode the directions are returned, since nothing else fits.
	always_comb begin
		rdata_nxt = {`GP_PORT_UPPER_READ, sel_r, (sel_r ? dir_r : level)}; // R6 R1
	end

	// Read data sits in a flip-flop loaded at the address phase edge, so a read right behind a write sees the old word.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (start && hit && !hwrite) begin
			hrdata <= rdata_nxt;
		end else begin
			hrdata <= 32'h0000_0000;
		end
	end

	// Zero wait states, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Assertions.
	// Reset release finds every pin released.
	property p_reset_inputs;
		@(posedge clk_sys) $rose(resetn) |-> (pin_oe_n == '1);
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pins driven after reset"); // R4

	// Every cycle in reset leaves the pins released, the data low and the read bus quiet.
	property p_in_reset;
		@(posedge clk_sys) (!resetn) |=> (pin_oe_n == '1 && pin_out == `GP_PORT_DATA_RESET && hrdata == 32'h0000_0000);
	endproperty
	a_in_reset: assert property (p_in_reset) else $error("reset state not reached"); // R4

	// The select bit and the output data also start from their reset values.
	property p_reset_state;
		@(posedge clk_sys) $rose(resetn) |-> (pin_out == `GP_PORT_DATA_RESET && sel_r == `GP_PORT_SEL_RESET);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("select or data not reset"); // R4

	// A direction write reaches the enables one cycle after its data phase.
	property p_dir_write;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r == gp_port_pkg::AHB_WRITE && hwdata[`GP_PORT_SEL_BIT])
			|=> (pin_oe_n == ~$past(hwdata[`GP_PORT_MD_MSB:`GP_PORT_MD_LSB]));
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write not applied"); // R3

	// A data write reaches the output levels one cycle after its data phase.
	property p_data_write;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r == gp_port_pkg::AHB_WRITE && !hwdata[`GP_PORT_SEL_BIT])
			|=> (pin_out == $past(hwdata[`GP_PORT_MD_MSB:`GP_PORT_MD_LSB]));
	endproperty
	a_data_write: assert property (p_data_write) else $error("data write not applied"); // R5

	// A data write never moves a direction, so input pins stay released.
	property p_data_keeps_dir;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r == gp_port_pkg::AHB_WRITE && !hwdata[`GP_PORT_SEL_BIT]) |=> $stable(pin_oe_n);
	endproperty
	a_data_keeps_dir: assert property (p_data_keeps_dir) else $error("data write moved direction"); // R7

	// A direction write keeps the stored data, so a pin turned output drives what was written before.
	property p_dir_keeps_data;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r == gp_port_pkg::AHB_WRITE && hwdata[`GP_PORT_SEL_BIT]) |=> $stable(pin_out);
	endproperty
	a_dir_keeps_data: assert property (p_dir_keeps_data) else $error("direction write moved data"); // R7

	// Directions change only through a direction write.
	property p_dir_hold;
		@(posedge clk_sys) disable iff (!resetn)
		!(phase_r == gp_port_pkg::AHB_WRITE && hwdata[`GP_PORT_SEL_BIT]) |=> $stable(pin_oe_n);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction moved without a write"); // R3

	// Output levels change only through a data write.
	property p_data_hold;
		@(posedge clk_sys) disable iff (!resetn)
		!(phase_r == gp_port_pkg::AHB_WRITE && !hwdata[`GP_PORT_SEL_BIT]) |=> $stable(pin_out);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("output level moved without a write"); // R5

	// Every register write stores the select bit.
	property p_sel_write;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r == gp_port_pkg::AHB_WRITE) |=> (sel_r == $past(hwdata[`GP_PORT_SEL_BIT]));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select bit not stored"); // R2

	// Without a write the select bit keeps its value.
	property p_sel_hold;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r != gp_port_pkg::AHB_WRITE) |=> $stable(sel_r);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select bit moved without a write"); // R2

	// A read leaves directions, levels and the select bit alone.
	property p_read_keeps;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r == gp_port_pkg::AHB_READ) |=> ($stable(pin_oe_n) && $stable(pin_out) && $stable(sel_r));
	endproperty
	a_read_keeps: assert property (p_read_keeps) else $error("read changed port state"); // R6

	// A mapped write opens a write data phase.
	property p_phase_write;
		@(posedge clk_sys) disable iff (!resetn)
		(start && hit && hwrite) |=> (phase_r == gp_port_pkg::AHB_WRITE);
	endproperty
	a_phase_write: assert property (p_phase_write) else $error("write data phase missing"); // R1

	// A mapped read opens a read data phase.
	property p_phase_read;
		@(posedge clk_sys) disable iff (!resetn)
		(start && hit && !hwrite) |=> (phase_r == gp_port_pkg::AHB_READ);
	endproperty
	a_phase_read: assert property (p_phase_read) else $error("read data phase missing"); // R1

	// An unmapped access is taken, then ignored: no data phase and a zero read.
	property p_unmapped;
		@(posedge clk_sys) disable iff (!resetn)
		(start && !hit) |=> (phase_r == gp_port_pkg::AHB_IDLE && hrdata == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access acted on"); // R1

	// Read data stands only in a read data phase and is zero otherwise.
	property p_rdata_quiet;
		@(posedge clk_sys) disable iff (!resetn)
		!(start && hit && !hwrite) |=> (hrdata == 32'h0000_0000);
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside a read"); // R1

	// The upper bits read as ones and the select position returns the stored select bit.
	property p_read_upper;
		@(posedge clk_sys) disable iff (!resetn)
		(start && hit && !hwrite)
			|=> (hrdata[31:`GP_PORT_SEL_BIT+1] == `GP_PORT_UPPER_READ && hrdata[`GP_PORT_SEL_BIT] == $past(sel_r));
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("upper read bits or select wrong"); // R2

	// In direction mode a read returns the directions, one bit per pin, 1 for output.
	property p_read_dir;
		@(posedge clk_sys) disable iff (!resetn)
		(start && hit && !hwrite && sel_r)
			|=> (hrdata[`GP_PORT_MD_MSB:`GP_PORT_MD_LSB] == ~$past(pin_oe_n));
	endproperty
	a_read_dir: assert property (p_read_dir) else $error("direction read back wrong"); // R2

	// A data-mode read returns the level that the read-back mux offered.
	property p_read_data;
		@(posedge clk_sys) disable iff (!resetn)
		(start && hit && !hwrite && !sel_r) |=> (hrdata[7:0] == $past(level));
	endproperty
	a_read_data: assert property (p_read_data) else $error("read of pins wrong"); // R6

	// Checked apart from the mux: driven pins read their data, released pins their synchronised level.
	property p_read_live;
		@(posedge clk_sys) disable iff (!resetn)
		(start && hit && !hwrite && !sel_r)
			|=> (hrdata[`GP_PORT_MD_MSB:`GP_PORT_MD_LSB]
				== (($past(pin_out) & ~$past(pin_oe_n)) | ($past(pin_sync) & $past(pin_oe_n))));
	endproperty
	a_read_live: assert property (p_read_live) else $error("pin read back wrong"); // R6

	// Output pins read back their driven value in data mode.
	property p_read_mixed;
		@(posedge clk_sys) disable iff (!resetn)
		(!sel_r) |-> (((level ^ pin_out) & ~pin_oe_n) == '0);
	endproperty
	a_read_mixed: assert property (p_read_mixed) else $error("output pin read mismatch"); // R6

	// Input pins read back their synchronised level in data mode.
	property p_read_inputs;
		@(posedge clk_sys) disable iff (!resetn)
		(!sel_r) |-> (((level ^ pin_sync) & pin_oe_n) == '0);
	endproperty
	a_read_inputs: assert property (p_read_inputs) else $error("input pin read mismatch"); // R6

	// Pins reach logic exactly two cycles late, once both stages hold samples taken out of reset.
	property p_sync_lag;
		@(posedge clk_sys) disable iff (!resetn)
		($past(resetn) && $past(resetn, 2)) |-> (pin_sync == $past(pin_in, 2));
	endproperty
	a_sync_lag: assert property (p_sync_lag) else $error("pin synchroniser latency wrong"); // R6

	// A transfer is never stretched and always answered OKAY.
	property p_ready;
		@(posedge clk_sys) disable iff (!resetn)
		start |=> (hreadyout && !hresp);
	endproperty
	a_ready: assert property (p_ready) else $error("slave not ready"); // R1

	// Every mapped data phase sees the slave ready with an OKAY answer.
	property p_phase_okay;
		@(posedge clk_sys) disable iff (!resetn)
		(phase_r != gp_port_pkg::AHB_IDLE) |-> (hreadyout && !hresp);
	endproperty
	a_phase_okay: assert property (p_phase_okay) else $error("data phase not answered"); // R1

	// Main scenarios: both write kinds, any read, a direction-mode read and an unmapped access.
	c_dir_write: cover property (@(posedge clk_sys) phase_r == gp_port_pkg::AHB_WRITE && hwdata[8]);
	c_data_write: cover property (@(posedge clk_sys) phase_r == gp_port_pkg::AHB_WRITE && !hwdata[8]);
	c_read: cover property (@(posedge clk_sys) phase_r == gp_port_pkg::AHB_READ);
	c_read_dir: cover property (@(posedge clk_sys) phase_r == gp_port_pkg::AHB_READ && sel_r);
	c_unmapped: cover property (@(posedge clk_sys) start && !hit);
endmodule // gp_port

// File: test/gp_board.sv
// Board-side model of the circuits wired to the general-purpose pins.
`timescale 1ns/1ps
module gp_board (
	// Device drive.
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	// Levels the board puts on released pins.
	input  wire logic [7:0] board_val,
	// Resolved pin levels.
	output logic      [7:0] pin_in
);
	// A driven pin shows the device level, a released pin the board level, never a stale value.
	assign pin_in = (pin_out & ~pin_oe_n) | (board_val & pin_oe_n);
endmodule // gp_board

// File: test/tb_general_purpose_pin_port.sv
// Self-checking bench for the general-purpose pin port.
`timescale 1ns/1ps
module tb_general_purpose_pin_port;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe_n;
	logic [7:0]  board_val = 8'ha5;
	logic [7:0]  exp_dir = 8'h00;
	logic [7:0]  exp_data = 8'h00;
	logic [31:0] rd;
	int          failures = 0;
	int          n_tests = 0;
	int          cycles = 0;
	// The 50 MHz system clock.
	always #10 clk_sys = ~clk_sys;
	gp_port u_dut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
	gp_board u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_val(board_val), .pin_in(pin_in));
	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: bus value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: pins %h, expected %h", $time, got, exp);
		end
	endtask
	// One single transfer; it waits on hready rather than assuming a latency.
	task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk_reg({31'h0, hresp}, 32'h0);
	endtask
	// Expected word: upper bits ones, then select, then directions or the per-pin mix.
	function automatic logic [31:0] exp_reg(input logic sel);
		exp_reg = {23'h7fffff, sel, sel ? exp_dir : ((exp_data & exp_dir) | (board_val & ~exp_dir))};
	endfunction
	task automatic rd_chk(input logic sel);
		access(1'b0, 32'h0, 32'h0);
		chk_reg(rd, exp_reg(sel));
	endtask
	// Writes the port word, then checks drive and enables once the update has landed.
	task automatic wr_reg(input logic [8:0] v);
		access(1'b1, 32'h0, {23'h0, v});
		if (v[8]) begin
			exp_dir = v[7:0];
		end else begin
			exp_data = v[7:0];
		end
		repeat (2) @(posedge clk_sys);
		chk_pin(pin_oe_n, ~exp_dir);
		chk_pin(pin_out & exp_dir, exp_data & exp_dir);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys); // Lets both synchroniser stages hold live pin samples.
		chk_pin(pin_oe_n, 8'hff);
		rd_chk(1'b0);
		wr_reg(9'h03c);
		wr_reg(9'h10f);
		rd_chk(1'b1);
		wr_reg(9'h055);
		board_val <= 8'h3c;
		repeat (3) @(posedge clk_sys);
		rd_chk(1'b0);
		wr_reg(9'h1ff);
		wr_reg(9'h0a5);
		access(1'b1, 32'h4, 32'h100);
		access(1'b0, 32'h4, 32'h0);
		chk_reg(rd, 32'h0);
		rd_chk(1'b0);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		exp_dir = 8'h00;
		exp_data = 8'h00;
		@(posedge clk_sys);
		chk_pin(pin_oe_n, 8'hff);
		rd_chk(1'b0);
		tally_and_finish();
	end
	// Cuts a hang short well past the expected run length.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			tally_and_finish();
		end
	end
endmodule // tb_general_purpose_pin_port
